// ### hdl/status_broadcast_can_id_scheduler.sv
module status_broadcast_can_id_scheduler #(
  parameter int TICK_CYCLES = bcast_pkg::TICK_CYCLES,  // Cycles per 0.1 s
  parameter int DISC_CYCLES = bcast_pkg::DISC_CYCLES,  // Discovery window
  parameter int NCELL       = 16,                       // Cells per broadcast
  parameter int NMOD        = 8                         // Module table entries
) (
  input  wire logic        clk_i,           // System clock
  input  wire logic        rst_i,           // Synchronous reset
  input  wire logic        ce_i,            // Clock enable
  input  wire logic [7:0]  address_i,       // Avalon byte address
  input  wire logic        read_i,          // Avalon read
  input  wire logic        write_i,         // Avalon write
  input  wire logic [31:0] writedata_i,     // Avalon write data
  output logic      [31:0] readdata_o,      // Avalon read data
  output logic             waitrequest_o,   // Avalon wait
  input  wire logic        sleep_i,         // Sleep state from system logic
  output logic             ser_bcast_o,     // Display broadcast pulse
  output logic             can_en_o,        // Applied CAN enable
  output logic      [2:0]  can_rate_o,      // Applied bit rate code
  output logic             cfg_mode_o,      // Configuration mode
  output logic             tx_valid_o,      // CAN frame request
  input  wire logic        tx_ready_i,      // CAN controller takes frame
  output logic      [28:0] tx_id_o,         // Frame identifier
  output logic             tx_ext_o,        // Extended format
  output logic      [7:0]  tx_index_o,      // Cell index for cell frames
  input  wire logic        rx_valid_i,      // Received frame valid
  output logic             rx_ready_o,      // Received frame taken
  input  wire logic [28:0] rx_id_i,         // Received identifier
  input  wire logic [63:0] rx_data_i,       // Received payload
  output logic             fwd_valid_o,     // Forwarded frame valid
  input  wire logic        fwd_ready_i,     // Serial formatter takes frame
  output logic      [92:0] fwd_frame_o      // Forwarded {id, data}
);

  // ****************************************
  // Register file
  // ****************************************
  logic [8:0]  ctrl_r, ctrl_nxt;
  logic [15:0] act_r, act_nxt, slp_r, slp_nxt;
  logic [12:0] bbase_r, bbase_nxt, dbase_r, dbase_nxt;
  logic        can_en_r, can_en_nxt;
  logic [2:0]  rate_r, rate_nxt;
  logic [NMOD-1:0] ok_r, ok_nxt, err_r, err_nxt, found_r, found_nxt;
  logic        ack_r, ack_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        cfg_r, cfg_nxt, disc_go;
  logic [31:0] disc_cnt_r, disc_cnt_nxt;
  logic [7:0]  nfound_r, nfound_nxt;
  logic [23:0] mod_r [NMOD];
  logic [23:0] mod_nxt [NMOD];
  logic        req, wr_do, rx_take, cap;
  logic [15:0] wval;
  logic [7:0]  mi;

  assign req = read_i | write_i;
  assign waitrequest_o = req & ~ack_r;
  assign wr_do = write_i & ack_r;
  assign readdata_o = rdata_r;
  assign wval = writedata_i[15:0];
  assign mi = 8'((address_i - bcast_pkg::OFS_MOD) >> 2);
  // Discovery replies carry the peripheral base response identifier
  assign cap = rx_take & cfg_r & can_en_r
             & (rx_id_i == bcast_pkg::make_id(dbase_r, bcast_pkg::MSG_DRESP,
                                              ctrl_r[bcast_pkg::BIT_EXT]));  // [RL11]

  // Bus decode, configuration, discovery and commit
  always_comb
  begin
    ctrl_nxt = ctrl_r; act_nxt = act_r; slp_nxt = slp_r;
    bbase_nxt = bbase_r; dbase_nxt = dbase_r;
    can_en_nxt = can_en_r; rate_nxt = rate_r;
    ok_nxt = ok_r; err_nxt = err_r; found_nxt = found_r;
    cfg_nxt = cfg_r; disc_cnt_nxt = disc_cnt_r; nfound_nxt = nfound_r;
    mod_nxt = mod_r;
    ack_nxt = req & ~ack_r;
    rdata_nxt = rdata_r;
    disc_go = 1'b0;
    if (req & ~ack_r & read_i)
    begin
      if (address_i == bcast_pkg::OFS_CTRL) rdata_nxt = {23'h0, ctrl_r};
      else if (address_i == bcast_pkg::OFS_ACT) rdata_nxt = {16'h0, act_r};
      else if (address_i == bcast_pkg::OFS_SLP) rdata_nxt = {16'h0, slp_r};
      else if (address_i == bcast_pkg::OFS_BBASE) rdata_nxt = {19'h0, bbase_r};
      else if (address_i == bcast_pkg::OFS_DBASE) rdata_nxt = {19'h0, dbase_r};
      else if (address_i == bcast_pkg::OFS_STAT)
        rdata_nxt = {16'h0, nfound_r, 2'h0, rate_r, can_en_r, cfg_r, sleep_i};
      else if (address_i == bcast_pkg::OFS_RESULT)
        rdata_nxt = {16'h0, 8'(err_r), 8'(ok_r)};
      else if (address_i >= bcast_pkg::OFS_MOD && mi < 8'(NMOD) && address_i[1:0] == 2'h0)
        rdata_nxt = {8'h0, mod_r[mi[$clog2(NMOD)-1:0]]};
      else rdata_nxt = 32'h0;
    end
    if (wr_do)
    begin
      if (address_i == bcast_pkg::OFS_CTRL)
      begin
        ctrl_nxt = writedata_i[8:0];
        if (writedata_i[bcast_pkg::BIT_SRST])
        begin
          can_en_nxt = writedata_i[bcast_pkg::BIT_CAN];  // [RL3]
          rate_nxt = (writedata_i[8:6] > bcast_pkg::RATE_MAX) ? rate_r
                                                             : writedata_i[8:6];  // [RL4]
        end
      end
      else if (address_i == bcast_pkg::OFS_ACT)  // Clamp into 0.1-25.0 s
        act_nxt = (wval < bcast_pkg::PER_MIN) ? bcast_pkg::PER_MIN :
                  (wval > bcast_pkg::ACT_MAX) ? bcast_pkg::ACT_MAX : wval;  // [RL2]
      else if (address_i == bcast_pkg::OFS_SLP)  // Clamp into 0.1-5000.0 s
        slp_nxt = (wval < bcast_pkg::PER_MIN) ? bcast_pkg::PER_MIN :
                  (wval > bcast_pkg::SLP_MAX) ? bcast_pkg::SLP_MAX : wval;  // [RL2]
      else if (address_i == bcast_pkg::OFS_BBASE) bbase_nxt = writedata_i[12:0];
      else if (address_i == bcast_pkg::OFS_DBASE) dbase_nxt = writedata_i[12:0];
      else if (address_i == bcast_pkg::OFS_DISC && writedata_i[0] && !cfg_r)
      begin
        disc_go = 1'b1;  // [RL12]
        cfg_nxt = 1'b1;
        disc_cnt_nxt = 32'(DISC_CYCLES);
        nfound_nxt = 8'h0;
        found_nxt = '0;
      end
      else if (address_i == bcast_pkg::OFS_COMMIT)
      begin
        ok_nxt = writedata_i[NMOD-1:0] & found_r;    // [RL13]
        err_nxt = writedata_i[NMOD-1:0] & ~found_r;  // [RL13]
      end
    end
    // Discovery window closes after its count, freeing normal operation
    if (cfg_r && !disc_go)
    begin
      disc_cnt_nxt = disc_cnt_r - 32'h1;
      if (disc_cnt_r == 32'h1) cfg_nxt = 1'b0;  // [RL12]
      if (cap && nfound_r < 8'(NMOD))
      begin
        mod_nxt[nfound_r[$clog2(NMOD)-1:0]] = rx_data_i[23:0];  // Serial and cell count
        found_nxt[nfound_r[$clog2(NMOD)-1:0]] = 1'b1;
        nfound_nxt = nfound_r + 8'h1;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_r <= bcast_pkg::CTRL_RST; act_r <= bcast_pkg::ACT_RST;
      slp_r <= bcast_pkg::SLP_RST; bbase_r <= bcast_pkg::BBASE_RST;  // [RL9]
      dbase_r <= bcast_pkg::DBASE_RST;  // [RL11]
      can_en_r <= bcast_pkg::CTRL_RST[bcast_pkg::BIT_CAN];
      rate_r <= bcast_pkg::CTRL_RST[8:6];
      ok_r <= '0; err_r <= '0; found_r <= '0; ack_r <= 1'b0; rdata_r <= 32'h0;
      cfg_r <= 1'b0; disc_cnt_r <= 32'h0; nfound_r <= 8'h0;
      for (int i = 0; i < NMOD; i++) mod_r[i] <= 24'h0;
    end
    else if (ce_i)
    begin
      ctrl_r <= ctrl_nxt; act_r <= act_nxt; slp_r <= slp_nxt;
      bbase_r <= bbase_nxt; dbase_r <= dbase_nxt;
      can_en_r <= can_en_nxt; rate_r <= rate_nxt;
      ok_r <= ok_nxt; err_r <= err_nxt; found_r <= found_nxt;
      ack_r <= ack_nxt; rdata_r <= rdata_nxt;
      cfg_r <= cfg_nxt; disc_cnt_r <= disc_cnt_nxt; nfound_r <= nfound_nxt;
      mod_r <= mod_nxt;
    end
  end

  assign can_en_o = can_en_r;
  assign can_rate_o = rate_r;
  assign cfg_mode_o = cfg_r;

  // ****************************************
  // Period timer
  // ****************************************
  logic [31:0] tick_r, tick_nxt;
  logic [15:0] tenth_r, tenth_nxt;
  logic        slp_d_r, fire_r, fire_nxt;
  logic [15:0] period;

  assign period = slp_d_r ? slp_r : act_r;  // [RL2]

  // Count 0.1 s steps, restart on state change, fire at end of period
  always_comb
  begin
    tick_nxt = tick_r + 32'h1;
    tenth_nxt = tenth_r;
    fire_nxt = 1'b0;
    if (sleep_i != slp_d_r)
    begin
      tick_nxt = 32'h0;  // [RL14]
      tenth_nxt = 16'h0;
    end
    else if (tick_r == 32'(TICK_CYCLES - 1))
    begin
      tick_nxt = 32'h0;
      tenth_nxt = tenth_r + 16'h1;  // [RL14]
      if (tenth_r + 16'h1 >= period)
      begin
        tenth_nxt = 16'h0;
        fire_nxt = ~cfg_nxt;  // [RL12]
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tick_r <= 32'h0; tenth_r <= 16'h0; slp_d_r <= 1'b0; fire_r <= 1'b0;
    end
    else if (ce_i)
    begin
      tick_r <= tick_nxt; tenth_r <= tenth_nxt; slp_d_r <= sleep_i; fire_r <= fire_nxt;
    end
  end

  assign ser_bcast_o = fire_r & ctrl_r[bcast_pkg::BIT_SER];  // [RL1]

  // ****************************************
  // CAN transmit sequencer
  // ****************************************
  bcast_pkg::tx_state_t st_r, st_nxt;
  logic [28:0] id_r, id_nxt;
  logic [7:0]  idx_r, idx_nxt;
  logic        ext, cells_on, go_on;

  assign ext = ctrl_r[bcast_pkg::BIT_EXT];  // [RL7]
  assign cells_on = ctrl_r[bcast_pkg::BIT_CELL];
  assign go_on = tx_valid_o & tx_ready_i;

  // Status frame, then per-cell frames; discovery request on demand
  always_comb
  begin
    st_nxt = st_r; id_nxt = id_r; idx_nxt = idx_r;
    case (st_r)
      bcast_pkg::ST_IDLE:
        if (disc_go && can_en_r)
        begin
          st_nxt = bcast_pkg::ST_DREQ;
          id_nxt = bcast_pkg::make_id(dbase_nxt, bcast_pkg::MSG_DREQ, ext);  // [RL11]
        end
        else if (fire_r && can_en_r && ctrl_r[bcast_pkg::BIT_PER])
        begin
          st_nxt = bcast_pkg::ST_STAT;  // [RL5]
          id_nxt = bcast_pkg::make_id(bbase_r, bcast_pkg::MSG_STATUS, ext);  // [RL9] [RL10]
        end
        else if (fire_r && can_en_r && cells_on)
        begin
          st_nxt = bcast_pkg::ST_CELL;  // [RL6]
          idx_nxt = 8'h0;
          id_nxt = bcast_pkg::make_id(bbase_r, bcast_pkg::MSG_CELL, ext);
        end
      bcast_pkg::ST_STAT:
        if (go_on)
        begin
          st_nxt = cells_on ? bcast_pkg::ST_CELL : bcast_pkg::ST_IDLE;
          idx_nxt = 8'h0;
          id_nxt = bcast_pkg::make_id(bbase_r, bcast_pkg::MSG_CELL, ext);
        end
      bcast_pkg::ST_CELL:
        if (go_on)
        begin
          idx_nxt = idx_r + 8'h1;  // [RL6]
          if (idx_r == 8'(NCELL - 1)) st_nxt = bcast_pkg::ST_IDLE;
        end
      default:
        if (go_on) st_nxt = bcast_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_r <= bcast_pkg::ST_IDLE; id_r <= 29'h0; idx_r <= 8'h0;
    end
    else if (ce_i)
    begin
      st_r <= st_nxt; id_r <= id_nxt; idx_r <= idx_nxt;
    end
  end

  assign tx_valid_o = (st_r != bcast_pkg::ST_IDLE);
  assign tx_id_o = id_r;
  assign tx_ext_o = ext;
  assign tx_index_o = idx_r;

  // ****************************************
  // Two-entry forwarding buffer
  // ****************************************
  logic [92:0] ent_r [2];
  logic [92:0] ent_nxt [2];
  logic [1:0]  cnt_r, cnt_nxt;
  logic        push, pop, fwd_on;

  // Frames are dropped when CAN or forwarding is off; a full buffer stalls the source
  assign fwd_on = can_en_r & ctrl_r[bcast_pkg::BIT_FWD] & ~cfg_r;  // [RL3] [RL8]
  assign rx_ready_o = ~fwd_on | (cnt_r != 2'h2);
  assign rx_take = rx_valid_i & rx_ready_o;
  assign push = rx_take & fwd_on;
  assign pop = fwd_valid_o & fwd_ready_i;

  always_comb
  begin
    ent_nxt = ent_r;
    cnt_nxt = cnt_r + 2'(push) - 2'(pop);
    if (pop) ent_nxt[0] = ent_r[1];
    if (push) ent_nxt[2'(cnt_r) - 2'(pop) == 2'h0 ? 0 : 1] = {rx_id_i, rx_data_i};  // [RL8]
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_r <= 2'h0; ent_r[0] <= 93'h0; ent_r[1] <= 93'h0;
    end
    else if (ce_i)
    begin
      cnt_r <= cnt_nxt; ent_r <= ent_nxt;
    end
  end

  assign fwd_valid_o = (cnt_r != 2'h0);
  assign fwd_frame_o = ent_r[0];

  // ****************************************
  // Checks
  // ****************************************
  a_ser_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    ser_bcast_o |-> ctrl_r[bcast_pkg::BIT_SER] && fire_r)  // [RL1]
    else $error("display broadcast while disabled");
  a_act_range: assert property (@(posedge clk_i) disable iff (rst_i)
    act_r >= 16'h0001 && act_r <= 16'h00fa)  // [RL2]
    else $error("active period out of range");
  a_can_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !(wr_do && ce_i && address_i == bcast_pkg::OFS_CTRL && writedata_i[31])
    |=> $stable(can_en_r) && $stable(rate_r))  // [RL3] [RL4]
    else $error("CAN setting applied without reset");
  a_tx_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(tx_valid_o) |-> can_en_r)  // [RL3]
    else $error("CAN transmit while disabled");
  a_status_first: assert property (@(posedge clk_i) disable iff (rst_i)
    fire_r && ce_i && can_en_r && ctrl_r[2] && st_r == bcast_pkg::ST_IDLE && !disc_go
    |=> st_r == bcast_pkg::ST_STAT)  // [RL5]
    else $error("status frame not started");
  a_ext_id: assert property (@(posedge clk_i) disable iff (rst_i)
    st_r == bcast_pkg::ST_STAT && ext |-> tx_id_o == {bbase_r, 16'h0000})  // [RL9]
    else $error("extended status identifier wrong");
  a_std_id: assert property (@(posedge clk_i) disable iff (rst_i)
    st_r == bcast_pkg::ST_STAT && !ext |-> tx_id_o == {18'h0, bbase_r[10:0]})  // [RL10]
    else $error("standard status identifier wrong");
  a_cfg_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    cfg_r |-> !ser_bcast_o)  // [RL12]
    else $error("broadcast during configuration mode");
  a_commit_res: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_do && ce_i && address_i == bcast_pkg::OFS_COMMIT
    |=> (ok_r | err_r) == $past(writedata_i[NMOD-1:0]))  // [RL13]
    else $error("commit result incomplete");
  a_buf_safe: assert property (@(posedge clk_i) disable iff (rst_i)
    fwd_valid_o && !fwd_ready_i |=> fwd_valid_o && $stable(fwd_frame_o))  // [RL8]
    else $error("forward buffer lost a stalled frame");

endmodule // status_broadcast_can_id_scheduler

// ### inc/bcast_pkg.sv
// Overview of operation
// RL1 - Serial display broadcast pulses each period only while its enable bit is set.
// RL2 - Period comes from active or sleep value: 0.1-25.0 s and 0.1-5000.0 s.
// RL3 - CAN enable gates all CAN transmit and receive; applied only at device reset.
// RL4 - Bit rate code picks 50/125/250/500/800/1000 kbps; applied only at device reset.
// RL5 - Periodic status frame goes on CAN using the same active and sleep periods.
// RL6 - Per-cell broadcast sends one frame per cell each period when enabled.
// RL7 - Format bit selects 29-bit or 11-bit identifiers; charger frames keep their own.
// RL8 - Forwarding re-emits each received frame toward serial; loss under load allowed.
// RL9 - Extended mode: broadcast base is the upper 13 bits, reset value 0x19B5.
// RL10 - Standard mode: broadcast base is added to each message's identifier offset.
// RL11 - Peripheral base, reset 0x0000, formed the same way for peripheral traffic.
// RL12 - Discovery enters configuration mode, suspends broadcasts, records serial and cells.
// RL13 - Commit request returns per-entry success or error result.
// RL14 - Period timers count 0.1 s steps and restart on active/sleep change.
package bcast_pkg;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_ACT    = 8'h04;
  localparam logic [7:0] OFS_SLP    = 8'h08;
  localparam logic [7:0] OFS_BBASE  = 8'h0c;
  localparam logic [7:0] OFS_DBASE  = 8'h10;
  localparam logic [7:0] OFS_STAT   = 8'h14;
  localparam logic [7:0] OFS_DISC   = 8'h18;
  localparam logic [7:0] OFS_COMMIT = 8'h1c;
  localparam logic [7:0] OFS_RESULT = 8'h20;
  localparam logic [7:0] OFS_MOD    = 8'h40;

  // ****************************************
  // Control fields
  // ****************************************
  localparam int BIT_SER  = 0;
  localparam int BIT_CAN  = 1;
  localparam int BIT_PER  = 2;
  localparam int BIT_CELL = 3;
  localparam int BIT_EXT  = 4;
  localparam int BIT_FWD  = 5;
  localparam int RATE_LSB = 6;
  localparam int BIT_SRST = 31;

  // ****************************************
  // Reset values and limits (periods in 0.1 s)
  // ****************************************
  localparam logic [8:0]  CTRL_RST  = 9'h0b3;
  localparam logic [15:0] ACT_RST   = 16'h000a;
  localparam logic [15:0] SLP_RST   = 16'h0064;
  localparam logic [15:0] ACT_MAX   = 16'h00fa;
  localparam logic [15:0] SLP_MAX   = 16'hc350;
  localparam logic [15:0] PER_MIN   = 16'h0001;
  localparam logic [12:0] BBASE_RST = 13'h19b5;
  localparam logic [12:0] DBASE_RST = 13'h0000;
  localparam logic [2:0]  RATE_MAX  = 3'h5;

  // ****************************************
  // Message identifier offsets
  // ****************************************
  localparam logic [15:0] MSG_STATUS = 16'h0000;
  localparam logic [15:0] MSG_CELL   = 16'h0010;
  localparam logic [15:0] MSG_DREQ   = 16'h0000;
  localparam logic [15:0] MSG_DRESP  = 16'h0001;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ      = 250;
  localparam int TICK_MS      = 100;
  localparam int DISC_US      = 1000;
  localparam int TICK_CYCLES  = TICK_MS * 1000 * CLK_MHZ;
  localparam int DISC_CYCLES  = DISC_US * CLK_MHZ;

  typedef enum logic [1:0] {ST_IDLE, ST_STAT, ST_CELL, ST_DREQ} tx_state_t;

  // Build 29-bit or 11-bit identifier from a base and an offset
  function automatic logic [28:0] make_id(input logic [12:0] base, input logic [15:0] ofs,
                                          input logic ext);
    logic [10:0] std;
    std = base[10:0] + ofs[10:0];
    make_id = ext ? {base, ofs} : {18'h00000, std};
  endfunction

endpackage

// ### tb/far_node.sv
module far_node (
  input  wire logic        clk_i,        // System clock
  input  wire logic        tx_valid_i,   // Frame offered by the scheduler
  output logic             tx_ready_o,   // Controller takes frame
  input  wire logic [28:0] tx_id_i,      // Offered identifier
  input  wire logic [7:0]  tx_index_i,   // Offered cell index
  output logic             rx_valid_o,   // Received frame valid
  input  wire logic        rx_ready_i,   // Scheduler takes frame
  output logic      [28:0] rx_id_o,      // Received identifier
  output logic      [63:0] rx_data_o,    // Received payload
  input  wire logic        fwd_valid_i,  // Forwarded frame valid
  output logic             fwd_ready_o,  // Serial formatter takes frame
  input  wire logic [92:0] fwd_frame_i   // Forwarded frame
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [36:0] txq[$];   // Taken {index, id}
  logic [92:0] fwdq[$];  // Taken forwarded frames
  logic [92:0] rxq[$];   // Frames still to deliver

  initial
  begin
    tx_ready_o  = 1'b0;
    fwd_ready_o = 1'b0;
    rx_valid_o  = 1'b0;
    rx_id_o     = 29'h0;
    rx_data_o   = 64'h0;
  end

  // Random stalls on both sinks; rx lines show a changed pattern when idle
  always @(posedge clk_i)
  begin
    tx_ready_o  <= 1'($urandom_range(1, 0));
    fwd_ready_o <= 1'($urandom_range(1, 0));
    if (tx_valid_i && tx_ready_o) txq.push_back({tx_index_i, tx_id_i});
    if (fwd_valid_i && fwd_ready_o) fwdq.push_back(fwd_frame_i);
    if (rx_valid_o && rx_ready_i) rxq.delete(0);
    if (rxq.size() > 0)
    begin
      rx_valid_o           <= 1'b1;
      {rx_id_o, rx_data_o} <= rxq[0];
    end
    else
    begin
      rx_valid_o <= 1'b0;
      rx_id_o    <= ~rx_id_o;
      rx_data_o  <= ~rx_data_o;
    end
  end
endmodule // far_node

// ### tb/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NC = 4;
  logic clk_i, rst_i, ce_i, read_i, write_i, sleep_i, tx_valid_o, tx_ready_i, tx_ext_o;
  logic rx_valid_i, rx_ready_o, fwd_valid_o, fwd_ready_i, ser_bcast_o, can_en_o, cfg_mode_o;
  logic waitrequest_o;
  logic [7:0]  address_i, tx_index_o;
  logic [31:0] writedata_i, readdata_o, q;
  logic [2:0]  can_rate_o, rate;
  logic [28:0] tx_id_o, rx_id_i;
  logic [63:0] rx_data_i;
  logic [92:0] fwd_frame_o, fr[$];
  logic [12:0] base;
  int failures, n_tests, n, p;

  // ****************************************
  // Design, far side and clock
  // ****************************************
  status_broadcast_can_id_scheduler #(.TICK_CYCLES(10), .DISC_CYCLES(50), .NCELL(NC), .NMOD(8))
    dut_u (.clk_i, .rst_i, .ce_i, .address_i, .read_i, .write_i, .writedata_i,
           .readdata_o, .waitrequest_o, .sleep_i, .ser_bcast_o, .can_en_o, .can_rate_o,
           .cfg_mode_o, .tx_valid_o, .tx_ready_i, .tx_id_o, .tx_ext_o, .tx_index_o,
           .rx_valid_i, .rx_ready_o, .rx_id_i, .rx_data_i, .fwd_valid_o, .fwd_ready_i,
           .fwd_frame_o);
  far_node peer_u (.clk_i, .tx_valid_i(tx_valid_o), .tx_ready_o(tx_ready_i), .tx_id_i(tx_id_o),
                   .tx_index_i(tx_index_o), .rx_valid_o(rx_valid_i), .rx_ready_i(rx_ready_o),
                   .rx_id_o(rx_id_i), .rx_data_o(rx_data_i), .fwd_valid_i(fwd_valid_o),
                   .fwd_ready_o(fwd_ready_i), .fwd_frame_i(fwd_frame_o));
  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // ****************************************
  // Bench tasks
  // ****************************************
  // Expected identifier for a base and message offset
  function automatic logic [28:0] exp_id(logic [12:0] b, logic [15:0] o, logic ext);
    return ext ? {b, o} : {18'h0, 11'(b[10:0] + o[10:0])};
  endfunction

  task automatic chk(input logic [92:0] got, input logic [92:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Avalon access held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    address_i   <= a;
    writedata_i <= d;
    write_i     <= wr;
    read_i      <= ~wr;
    do begin @(posedge clk_i); k++; end while (waitrequest_o !== 1'b0 && k < 100);
    if (waitrequest_o !== 1'b0) failures++;
    q = readdata_o;
    write_i <= 1'b0;
    read_i  <= 1'b0;
    @(posedge clk_i);
  endtask

  // Cycles until the next display pulse
  task automatic wait_pulse(output int c);
    c = 0;
    do begin @(posedge clk_i); c++; end while (ser_bcast_o !== 1'b1 && c < 5000);
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    repeat (40000) @(posedge clk_i);
    failures++;
    final_report;
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    {rst_i, read_i, write_i, sleep_i} = 4'b1000;
    ce_i        = 1'b1;
    address_i   = 8'h00;
    writedata_i = 32'h0;
    void'($urandom(32'ha47f));
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(can_en_o, 1'b1);
    chk(can_rate_o, 3'h2);
    // Reset values, unmapped place reads zero
    bus(0, 8'h00, 0); chk(q & 32'h1ff, 32'hb3);
    bus(0, 8'h04, 0); chk(q, 32'h0a);
    bus(0, 8'h08, 0); chk(q, 32'h64);
    bus(0, 8'h0c, 0); chk(q, 32'h19b5);
    bus(0, 8'h10, 0); chk(q, 32'h0);
    bus(1, 8'h2c, 32'h5); bus(0, 8'h2c, 0); chk(q, 32'h0);
    // Period limits
    bus(1, 8'h04, 32'h0); bus(0, 8'h04, 0); chk(q, 32'h1);
    bus(1, 8'h04, 32'hffff); bus(0, 8'h04, 0); chk(q, 32'hfa);
    bus(1, 8'h08, 32'hffff); bus(0, 8'h08, 0); chk(q, 32'hc350);
    // Rate codes apply only at soft reset; illegal codes keep the old one
    rate = 3'h2;
    for (int r = 0; r < 8; r++)
    begin
      bus(1, 8'h00, 32'hb3 & ~32'h1c0 | (r << 6));
      chk(can_rate_o, rate);
      bus(1, 8'h00, 32'h8000_0033 | (r << 6));
      if (r <= 5) rate = 3'(r);
      chk(can_rate_o, rate);
    end
    bus(1, 8'h00, 32'h8000_00b3);
    // Display period in active and sleep states, restart on change
    bus(1, 8'h04, 32'h2);
    bus(1, 8'h08, 32'h3);
    wait_pulse(n); wait_pulse(n); chk(n, 20);
    repeat (5) @(posedge clk_i);
    sleep_i <= 1'b1;
    wait_pulse(n); chk(n >= 30 && n <= 32, 1'b1);
    wait_pulse(n); chk(n, 30);
    // Clock enable low freezes the period count
    ce_i <= 1'b0;
    p = 0;
    repeat (50) begin @(posedge clk_i); p += ser_bcast_o; end
    ce_i <= 1'b1;
    chk(p, 0);
    wait_pulse(n); chk(n, 30);
    sleep_i <= 1'b0;
    bus(1, 8'h00, 32'hb2);
    p = 0;
    repeat (100) begin @(posedge clk_i); p += ser_bcast_o; end
    chk(p, 0);
    // Status and cell frames, extended then standard identifiers
    bus(1, 8'h04, 32'hfa);
    for (int m = 0; m < 2; m++)
    begin
      base = m ? 13'($urandom) : 13'h19b5;
      bus(1, 8'h0c, {19'h0, base});
      bus(1, 8'h00, 32'h8e | ((1 - m) << 4));
      peer_u.txq.delete();
      n = 0;
      while (peer_u.txq.size() < NC + 1 && n < 4000) begin @(posedge clk_i); n++; end
      chk(peer_u.txq[0][28:0], exp_id(base, 16'h0, m == 0));
      for (int c = 0; c < NC; c++)
        chk(peer_u.txq[c + 1], {8'(c), exp_id(base, 16'h10, m == 0)});
      chk(tx_ext_o, m == 0);
    end
    // CAN disabled gates transmission
    bus(1, 8'h00, 32'h8000_008c);
    chk(can_en_o, 1'b0);
    bus(1, 8'h04, 32'h1);
    peer_u.txq.delete();
    repeat (60) @(posedge clk_i);
    chk(peer_u.txq.size(), 0);
    // Forwarding in order with stalls, then nothing when disabled
    bus(1, 8'h00, 32'h8000_00b2);
    for (int i = 0; i < 8; i++) fr.push_back({29'($urandom), $urandom, $urandom});
    foreach (fr[i]) peer_u.rxq.push_back(fr[i]);
    n = 0;
    while (peer_u.fwdq.size() < 8 && n < 500) begin @(posedge clk_i); n++; end
    foreach (fr[i]) chk(peer_u.fwdq[i], fr[i]);
    bus(1, 8'h00, 32'h92);
    peer_u.fwdq.delete();
    peer_u.rxq.push_back(fr[0]);
    repeat (40) @(posedge clk_i);
    chk(peer_u.fwdq.size(), 0);
    // Discovery, then commit of one found and one missing entry
    bus(1, 8'h00, 32'hb3);
    peer_u.txq.delete();
    bus(1, 8'h18, 32'h1);
    chk(cfg_mode_o, 1'b1);
    peer_u.rxq.push_back({exp_id(13'h0, 16'h1, 1'b1), 64'h14_00c5});
    n = 0;
    p = 0;
    while (cfg_mode_o === 1'b1 && n < 300) begin @(posedge clk_i); n++; p += ser_bcast_o; end
    chk(p, 0);
    chk(cfg_mode_o, 1'b0);
    chk(peer_u.txq[0][28:0], exp_id(13'h0, 16'h0, 1'b1));
    bus(0, 8'h40, 0); chk(q, 32'h14_00c5);
    bus(0, 8'h14, 0); chk(q[15:8], 8'h1);
    bus(1, 8'h1c, 32'h3);
    bus(0, 8'h20, 0); chk(q, 32'h0201);
    final_report;
  end
endmodule // tb
